// File: core/cpu_gate_params.svh
// timing counts, register offsets and encodings of the cpu timing and flash gating block
// assumes it is included by its bare name from the package and the design files
`ifndef CPU_GATE_PARAMS_SVH
`define CPU_GATE_PARAMS_SVH

// interrupt entry length in core clock cycles
`define IRQ_ENTRY_CYCLES   5'h0d
// page size is 2**PAGE_BITS bytes of program space
`define PAGE_BITS          8
// opcode of the supervisory call instruction
`define SUPV_CALL_OPCODE   8'h00
// data ram size in bytes and its address width
`define DATA_RAM_BYTES     256
`define DATA_RAM_AW        8
// number of user flash rows and of auxiliary rows that follow them
`define USER_ROWS          8'h80
`define AUX_ROWS           8'h04
// flash control register offsets
`define FREG_CTRL          8'h00
`define FREG_ROW           8'h01
`define FREG_STATUS        8'h02
// field positions in the control and status registers
`define CTRL_OP_LSB        0
`define STAT_BUSY_BIT      0
`define STAT_ROM_BIT       1
`define STAT_REFUSED_BIT   2
// reset values
`define ROW_RESET          8'h00
`define RDATA_RESET        8'h00

`endif

// File: core/cpu_gate_pkg.sv
// types shared by the cpu timing and flash gating block
// assumes cpu_gate_params.svh sits on the include path
package cpu_gate_pkg;
`include "cpu_gate_params.svh"

   // flash operation codes held in the control register
   typedef enum logic [1:0] {
      FOP_NONE,
      FOP_ERASE_ROW,
      FOP_PROG_ROW,
      FOP_ERASE_ALL
   } flash_op_t;

endpackage

// File: core/data_ram.sv
// single port data ram with registered read data
// assumes one access per enabled cycle from the core clock domain
`timescale 1ns/10ps
`default_nettype none

module data_ram #(
   parameter int DEPTH = 256,
   parameter int AW    = 8
) (
   input  wire logic          clk,
   input  wire logic          ce,
   input  wire logic          req,
   input  wire logic          wr,
   input  wire logic [AW-1:0] addr,
   input  wire logic [7:0]    wdata,
   output logic      [7:0]    rdata_r
);

   logic [7:0] mem [DEPTH];

   // storage has no reset; read data are held until the next read
   always_ff @(posedge clk) begin
      if (ce && req) begin
         if (wr) begin
            mem[addr] <= wdata;
         end else begin
            rdata_r <= mem[addr];
         end
      end
   end

endmodule

`default_nettype wire

// File: core/cpu_timing_flash_gating.sv
// processor side timing adjustments and flash register gating
// assumes all request inputs come from core logic on clk, so none is synchronised
`timescale 1ns/10ps
`default_nettype none
`include "cpu_gate_params.svh"

module cpu_timing_flash_gating
   import cpu_gate_pkg::*;
#(
   parameter logic [7:0] USER_ROWS = `USER_ROWS,
   parameter logic [7:0] AUX_ROWS  = `AUX_ROWS
) (
   input  wire logic                    clk,
   input  wire logic                    rst,
   input  wire logic                    ce,
   input  wire logic                    instrValid,
   input  wire logic [7:0]              instrOpcode,
   input  wire logic [15:0]             instrAddr,
   input  wire logic [1:0]              instrLen,
   input  wire logic [3:0]              instrBaseCycles,
   input  wire logic [7:0]              accIn,
   input  wire logic                    irqTake,
   input  wire logic                    romReturn,
   input  wire logic                    fregReq,
   input  wire logic                    fregWr,
   input  wire logic [7:0]              fregAddr,
   input  wire logic [7:0]              fregWdata,
   input  wire logic                    flashAck,
   input  wire logic                    ramReq,
   input  wire logic                    ramWr,
   input  wire logic [`DATA_RAM_AW-1:0] ramAddr,
   input  wire logic [7:0]              ramWdata,
   output logic      [7:0]              ramRdata,
   output logic      [4:0]              instrCycles_r,
   output logic                         instrCyclesValid_r,
   output logic                         irqEntryBusy_r,
   output logic                         vectorFetch_r,
   output logic                         supervisoryRomMode_r,
   output logic                         supervisoryEntry_r,
   output logic      [7:0]              supervisoryFunc_r,
   output logic                         fregAck_r,
   output logic      [7:0]              fregRdata_r,
   output logic                         flashStrobe_r,
   output logic      [1:0]              flashOp_r,
   output logic      [7:0]              flashRow_r
);

   // ************************************************************
   // instruction timing
   // ************************************************************
   logic [4:0]  instrCycles_nxt;
   logic        instrCyclesValid_nxt;
   logic [15:0] lastByteAddr;

   // one extra cycle when first and last byte sit on different pages
   always_comb begin
      lastByteAddr         = instrAddr + 16'(instrLen) - 16'h0001;
      instrCycles_nxt      = instrCycles_r;
      instrCyclesValid_nxt = 1'b0;
      if (instrValid) begin
         instrCyclesValid_nxt = 1'b1;
         instrCycles_nxt      = {1'b0, instrBaseCycles};
         if (instrLen != 2'h0 && instrAddr[15:`PAGE_BITS] != lastByteAddr[15:`PAGE_BITS]) begin
            instrCycles_nxt = {1'b0, instrBaseCycles} + 5'h01;
         end
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         instrCycles_r      <= 5'h00;
         instrCyclesValid_r <= 1'b0;
      end else if (ce) begin
         instrCycles_r      <= instrCycles_nxt;
         instrCyclesValid_r <= instrCyclesValid_nxt;
      end
   end

   // ************************************************************
   // interrupt entry
   // ************************************************************
   logic [4:0] entryCount_r, entryCount_nxt;
   logic       irqEntryBusy_nxt, vectorFetch_nxt;

   // a second irqTake during entry is ignored; the core never takes one there
   always_comb begin
      entryCount_nxt   = entryCount_r;
      irqEntryBusy_nxt = irqEntryBusy_r;
      vectorFetch_nxt  = 1'b0;
      if (!irqEntryBusy_r && irqTake) begin
         irqEntryBusy_nxt = 1'b1;
         entryCount_nxt   = `IRQ_ENTRY_CYCLES - 5'h01;
      end else if (irqEntryBusy_r) begin
         if (entryCount_r == 5'h00) begin
            irqEntryBusy_nxt = 1'b0;
            vectorFetch_nxt  = 1'b1;
         end else begin
            entryCount_nxt = entryCount_r - 5'h01;
         end
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         entryCount_r   <= 5'h00;
         irqEntryBusy_r <= 1'b0;
         vectorFetch_r  <= 1'b0;
      end else if (ce) begin
         entryCount_r   <= entryCount_nxt;
         irqEntryBusy_r <= irqEntryBusy_nxt;
         vectorFetch_r  <= vectorFetch_nxt;
      end
   end

   // ************************************************************
   // supervisory rom flag
   // ************************************************************
   logic       romMode_nxt, supervisoryEntry_nxt;
   logic [7:0] supervisoryFunc_nxt;

   // entry wins over a return in the same cycle so a call is never lost
   always_comb begin
      romMode_nxt          = supervisoryRomMode_r;
      supervisoryEntry_nxt = 1'b0;
      supervisoryFunc_nxt  = supervisoryFunc_r;
      if (romReturn) begin
         romMode_nxt = 1'b0;
      end
      if (instrValid && instrOpcode == `SUPV_CALL_OPCODE) begin
         romMode_nxt          = 1'b1;
         supervisoryEntry_nxt = 1'b1;
         supervisoryFunc_nxt  = accIn;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         supervisoryRomMode_r <= 1'b0;
         supervisoryEntry_r   <= 1'b0;
         supervisoryFunc_r    <= 8'h00;
      end else if (ce) begin
         supervisoryRomMode_r <= romMode_nxt;
         supervisoryEntry_r   <= supervisoryEntry_nxt;
         supervisoryFunc_r    <= supervisoryFunc_nxt;
      end
   end

   // ************************************************************
   // gated flash control registers and erase sequencer
   // ************************************************************
   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_WAIT,
      SEQ_SWEEP
   } seq_state_t;
   seq_state_t seqState_r, seqState_nxt;
   logic [7:0] rowReg_r, rowReg_nxt, fregRdata_nxt, flashRow_nxt;
   logic       refused_r, refused_nxt, fregAck_nxt, flashStrobe_nxt, gateOpen;
   logic [1:0] flashOp_nxt;
   flash_op_t  reqOp;

   // registers exist only in rom mode
   // every flash operation starts from this gate
   // user code is refused and sees zero
   assign gateOpen = supervisoryRomMode_r;

   always_comb begin
      reqOp           = flash_op_t'(fregWdata[`CTRL_OP_LSB +: 2]);
      seqState_nxt    = seqState_r;
      rowReg_nxt      = rowReg_r;
      refused_nxt     = refused_r;
      fregAck_nxt     = fregReq;          // every request is answered, even when closed
      fregRdata_nxt   = `RDATA_RESET;
      flashStrobe_nxt = 1'b0;
      flashOp_nxt     = flashOp_r;
      flashRow_nxt    = flashRow_r;
      if (fregReq && !gateOpen && fregWr) begin
         refused_nxt = 1'b1;
      end
      if (fregReq && gateOpen) begin
         if (!fregWr) begin
            case (fregAddr)
               `FREG_ROW: begin
                  fregRdata_nxt = rowReg_r;
               end
               `FREG_STATUS: begin
                  fregRdata_nxt[`STAT_BUSY_BIT]    = (seqState_r != SEQ_IDLE);
                  fregRdata_nxt[`STAT_ROM_BIT]     = supervisoryRomMode_r;
                  fregRdata_nxt[`STAT_REFUSED_BIT] = refused_r;
               end
               default: begin
                  fregRdata_nxt = `RDATA_RESET;
               end
            endcase
         end else if (fregAddr == `FREG_ROW) begin
            rowReg_nxt = fregWdata;
         end else if (fregAddr == `FREG_STATUS) begin
            refused_nxt = 1'b0;           // a write to the status register in rom mode clears the sticky refusal
         end else if (fregAddr == `FREG_CTRL && seqState_r == SEQ_IDLE && reqOp != FOP_NONE) begin
            flashStrobe_nxt = 1'b1;
            flashOp_nxt     = fregWdata[`CTRL_OP_LSB +: 2];
            flashRow_nxt    = rowReg_r;
            seqState_nxt    = SEQ_WAIT;
            // aux rows live above the user rows; erase all never reads the row register
            if (reqOp != FOP_ERASE_ALL && rowReg_r >= USER_ROWS + AUX_ROWS) begin
               flashStrobe_nxt = 1'b0;
               flashOp_nxt     = flashOp_r;
               flashRow_nxt    = flashRow_r;
               seqState_nxt    = SEQ_IDLE;
               refused_nxt     = 1'b1;
            end
            // erase all walks user rows only
            if (reqOp == FOP_ERASE_ALL) begin
               flashOp_nxt  = FOP_ERASE_ROW;
               flashRow_nxt = 8'h00;
               seqState_nxt = SEQ_SWEEP;
            end
         end
      end
      case (seqState_r)
         SEQ_IDLE: begin
         end
         SEQ_WAIT: begin
            if (flashAck) begin
               seqState_nxt = SEQ_IDLE;
            end
         end
         SEQ_SWEEP: begin
            if (flashAck) begin
               if (flashRow_r == USER_ROWS - 8'h01) begin
                  seqState_nxt = SEQ_IDLE;
               end else begin
                  flashRow_nxt    = flashRow_r + 8'h01;
                  flashStrobe_nxt = 1'b1;
               end
            end
         end
         default: begin
            seqState_nxt = SEQ_IDLE;
         end
      endcase
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         seqState_r    <= SEQ_IDLE;
         rowReg_r      <= `ROW_RESET;
         refused_r     <= 1'b0;
         fregAck_r     <= 1'b0;
         fregRdata_r   <= `RDATA_RESET;
         flashStrobe_r <= 1'b0;
         flashOp_r     <= FOP_NONE;
         flashRow_r    <= `ROW_RESET;
      end else if (ce) begin
         seqState_r    <= seqState_nxt;
         rowReg_r      <= rowReg_nxt;
         refused_r     <= refused_nxt;
         fregAck_r     <= fregAck_nxt;
         fregRdata_r   <= fregRdata_nxt;
         flashStrobe_r <= flashStrobe_nxt;
         flashOp_r     <= flashOp_nxt;
         flashRow_r    <= flashRow_nxt;
      end
   end

   // ************************************************************
   // data ram
   // ************************************************************
   // 256 bytes, 8-bit address
   data_ram #(.DEPTH (`DATA_RAM_BYTES), .AW (`DATA_RAM_AW)) u_ram (
      .clk (clk), .ce (ce), .req (ramReq), .wr (ramWr),
      .addr (ramAddr), .wdata (ramWdata), .rdata_r (ramRdata)
   );

endmodule

`default_nettype wire

// File: tb/cpu_gate_properties.sv
// assertion checker for the cpu timing and flash gating block
// assumes it is bound to the block and sees only the block's ports
`timescale 1ns/10ps
`default_nettype none
`include "cpu_gate_params.svh"

module cpu_gate_properties
   import cpu_gate_pkg::*;
#(
   parameter logic [7:0] USER_ROWS = `USER_ROWS,
   parameter logic [7:0] AUX_ROWS  = `AUX_ROWS
) (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        ce,
   input wire logic        instrValid,
   input wire logic [7:0]  instrOpcode,
   input wire logic [15:0] instrAddr,
   input wire logic [1:0]  instrLen,
   input wire logic [3:0]  instrBaseCycles,
   input wire logic [7:0]  accIn,
   input wire logic        irqTake,
   input wire logic        romReturn,
   input wire logic        fregReq,
   input wire logic        fregWr,
   input wire logic [7:0]  fregAddr,
   input wire logic [4:0]  instrCycles_r,
   input wire logic        instrCyclesValid_r,
   input wire logic        irqEntryBusy_r,
   input wire logic        vectorFetch_r,
   input wire logic        supervisoryRomMode_r,
   input wire logic        supervisoryEntry_r,
   input wire logic [7:0]  supervisoryFunc_r,
   input wire logic        fregAck_r,
   input wire logic [7:0]  fregRdata_r,
   input wire logic        flashStrobe_r,
   input wire logic [7:0]  flashRow_r
);
   // ***************************************
   // expected figures and properties
   // ***************************************
   logic [15:0] lastAddr;
   logic [4:0]  expCycles;
   logic        call;

   // length 0 means no crossing check, so it never adds the extra cycle
   assign lastAddr = instrAddr + 16'(instrLen) - 16'h0001;
   assign expCycles = 5'(instrBaseCycles) + 5'((instrLen != 2'h0 && lastAddr[15:8] != instrAddr[15:8]) ? 1 : 0);
   assign call = instrValid && instrOpcode == `SUPV_CALL_OPCODE;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_irqEntry;
      ce && irqTake && !irqEntryBusy_r |=>
         irqEntryBusy_r[*8] ##1 irqEntryBusy_r[*5] ##1 (!irqEntryBusy_r && vectorFetch_r);
   endproperty
   a_irqEntry: assert property (p_irqEntry) else $error("interrupt entry length wrong");
   property p_vecFetch; vectorFetch_r |-> $past(irqEntryBusy_r) && !irqEntryBusy_r; endproperty
   a_vecFetch: assert property (p_vecFetch) else $error("vector fetch without entry");
   property p_cycles; ce && instrValid |=> instrCyclesValid_r && instrCycles_r == $past(expCycles); endproperty
   a_cycles: assert property (p_cycles) else $error("instruction cycle count wrong");
   property p_romEntry;
      ce && call |=> supervisoryEntry_r && supervisoryRomMode_r && supervisoryFunc_r == $past(accIn);
   endproperty
   a_romEntry: assert property (p_romEntry) else $error("supervisory call not taken");
   property p_userRead;
      ce && fregReq && !fregWr && !supervisoryRomMode_r |=> fregAck_r && fregRdata_r == 8'h00;
   endproperty
   a_userRead: assert property (p_userRead) else $error("flash register visible to user code");
   property p_userWrite;
      ce && fregReq && fregWr && fregAddr == `FREG_CTRL && !supervisoryRomMode_r |=> !flashStrobe_r;
   endproperty
   a_userWrite: assert property (p_userWrite) else $error("flash started from user code");
   property p_romExit; ce && romReturn && !call |=> !supervisoryRomMode_r; endproperty
   a_romExit: assert property (p_romExit) else $error("rom flag kept after return");
   property p_modeHold; supervisoryRomMode_r && !romReturn |=> supervisoryRomMode_r; endproperty
   a_modeHold: assert property (p_modeHold) else $error("rom flag dropped");
   property p_rowRange; flashStrobe_r |-> flashRow_r < USER_ROWS + AUX_ROWS; endproperty
   a_rowRange: assert property (p_rowRange) else $error("flash row out of range");

   c_irq: cover property (ce && irqTake && !irqEntryBusy_r);
   c_call: cover property (ce && call);
   c_cross: cover property (ce && instrValid && expCycles != 5'(instrBaseCycles));
   c_auxRow: cover property (flashStrobe_r && flashRow_r >= USER_ROWS);
endmodule

bind cpu_timing_flash_gating cpu_gate_properties #(.USER_ROWS(USER_ROWS), .AUX_ROWS(AUX_ROWS)) u_props (
   .clk, .rst, .ce, .instrValid, .instrOpcode, .instrAddr, .instrLen, .instrBaseCycles, .accIn, .irqTake,
   .romReturn, .fregReq, .fregWr, .fregAddr, .instrCycles_r, .instrCyclesValid_r, .irqEntryBusy_r,
   .vectorFetch_r, .supervisoryRomMode_r, .supervisoryEntry_r, .supervisoryFunc_r, .fregAck_r, .fregRdata_r,
   .flashStrobe_r, .flashRow_r);
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the cpu timing and flash gating block
// assumes package, params header and design sources are compiled first
`timescale 1ns/10ps
`default_nettype none
`include "cpu_gate_params.svh"

module tb
   import cpu_gate_pkg::*;
;
   // ***************************************
   // stimulus, model and checks
   // ***************************************
   logic                    clk, rst, ce, instrValid, irqTake, romReturn, fregReq, fregWr, flashAck, ramReq, ramWr;
   logic [7:0]              instrOpcode, accIn, fregAddr, fregWdata, ramWdata, ramRdata, supervisoryFunc_r;
   logic [7:0]              fregRdata_r, flashRow_r, q;
   logic [15:0]             instrAddr;
   logic [1:0]              instrLen, flashOp_r;
   logic [3:0]              instrBaseCycles;
   logic [`DATA_RAM_AW-1:0] ramAddr;
   logic [4:0]              instrCycles_r;
   logic                    instrCyclesValid_r, irqEntryBusy_r, vectorFetch_r, supervisoryRomMode_r;
   logic                    supervisoryEntry_r, fregAck_r, flashStrobe_r, sawStrobe;
   logic [31:0]             seed;
   logic [7:0]              mem [256];
   logic [7:0]              aq [$];
   int                      nFail, checkCount, n, r;

   cpu_timing_flash_gating u_cpu_timing_flash_gating (.clk, .rst, .ce, .instrValid, .instrOpcode, .instrAddr,
      .instrLen, .instrBaseCycles, .accIn, .irqTake, .romReturn, .fregReq, .fregWr, .fregAddr, .fregWdata,
      .flashAck, .ramReq, .ramWr, .ramAddr, .ramWdata, .ramRdata, .instrCycles_r, .instrCyclesValid_r,
      .irqEntryBusy_r, .vectorFetch_r, .supervisoryRomMode_r, .supervisoryEntry_r, .supervisoryFunc_r,
      .fregAck_r, .fregRdata_r, .flashStrobe_r, .flashOp_r, .flashRow_r);

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checkCount++;
      if (seen !== exp) begin
         nFail++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic completeRun;
      $display("checks %0d mismatches %0d", checkCount, nFail);
      if (nFail == 0 && checkCount > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // valid is left high so back-to-back instructions need no idle cycle
   task automatic instr(input logic [7:0] op, input logic [15:0] a, input logic [1:0] len, input logic [3:0] b);
      int last;
      instrValid = 1'b1;
      instrOpcode = op;
      instrAddr = a;
      instrLen = len;
      instrBaseCycles = b;
      last = int'(a) + int'(len) - 1;
      @(negedge clk);
      chk(instrCyclesValid_r, 1'b1);
      chk(instrCycles_r, b + ((len != 0 && (last >> 8) % 256 != a[15:8]) ? 1 : 0));
   endtask

   task automatic freg(input logic w, input logic [7:0] a, input logic [7:0] d);
      fregReq = 1'b1;
      fregWr = w;
      fregAddr = a;
      fregWdata = d;
      @(negedge clk);
      chk(fregAck_r, 1'b1);
      q = fregRdata_r;
      sawStrobe = flashStrobe_r;
   endtask

   task automatic waitStrobe;
      for (int i = 0; i < 16 && flashStrobe_r !== 1'b1; i++) @(negedge clk);
      if (flashStrobe_r !== 1'b1) begin
         nFail++;
         completeRun;
      end
   endtask

   // flash answers after a random stall of one to four cycles
   task automatic ackFlash;
      seed = lfsr(seed);
      repeat (1 + seed[1:0]) @(negedge clk);
      flashAck = 1'b1;
      @(negedge clk);
      flashAck = 1'b0;
   endtask

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   initial begin
      {rst, ce} = 2'b11;
      {instrValid, irqTake, romReturn, fregReq, fregWr, flashAck, ramReq, ramWr} = '0;
      {instrOpcode, accIn, fregAddr, fregWdata, ramWdata, ramAddr, instrAddr, instrLen, instrBaseCycles} = '0;
      seed = 32'h3f34;
      nFail = 0;
      checkCount = 0;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      // user code: registers read zero, writes refused and remembered
      freg(1'b0, `FREG_STATUS, 8'h00);
      chk(q, 8'h00);
      freg(1'b1, `FREG_CTRL, 8'h01);
      chk(sawStrobe, 1'b0);
      fregReq = 1'b0;
      accIn = 8'h5a;
      instr(`SUPV_CALL_OPCODE, 16'h0010, 2'h1, 4'h4);
      instrValid = 1'b0;
      chk({supervisoryEntry_r, supervisoryRomMode_r, supervisoryFunc_r}, {2'b11, 8'h5a});
      freg(1'b0, `FREG_STATUS, 8'h00);
      chk(q, 8'h06);
      freg(1'b1, `FREG_STATUS, 8'h00);
      freg(1'b1, `FREG_ROW, 8'h82);
      freg(1'b1, `FREG_CTRL, 8'h01);
      fregReq = 1'b0;
      chk({sawStrobe, flashOp_r, flashRow_r}, {1'b1, FOP_ERASE_ROW, 8'h82});
      ackFlash;
      freg(1'b1, `FREG_CTRL, 8'h02);
      chk({sawStrobe, flashOp_r}, {1'b1, FOP_PROG_ROW});
      freg(1'b1, `FREG_CTRL, 8'h01);
      chk(sawStrobe, 1'b0);
      freg(1'b0, `FREG_ROW, 8'h00);
      chk({q, flashOp_r}, {8'h82, FOP_PROG_ROW});
      freg(1'b0, `FREG_STATUS, 8'h00);
      fregReq = 1'b0;
      chk(q, 8'h03);
      ackFlash;
      freg(1'b1, `FREG_ROW, 8'h84);
      freg(1'b1, `FREG_CTRL, 8'h01);
      chk(sawStrobe, 1'b0);
      freg(1'b0, `FREG_STATUS, 8'h00);
      chk(q, 8'h06);
      freg(1'b1, `FREG_STATUS, 8'h00);
      freg(1'b1, `FREG_CTRL, 8'h03);
      fregReq = 1'b0;
      chk(sawStrobe, 1'b1);
      for (r = 0; r < 128; r++) begin
         if (r > 0) waitStrobe;
         chk(flashRow_r, r);
         ackFlash;
      end
      repeat (4) begin
         chk(flashStrobe_r, 1'b0);
         @(negedge clk);
      end
      romReturn = 1'b1;
      @(negedge clk);
      romReturn = 1'b0;
      chk(supervisoryRomMode_r, 1'b0);
      // a call and a return in one cycle: the call wins
      romReturn = 1'b1;
      instr(`SUPV_CALL_OPCODE, 16'h0020, 2'h1, 4'h4);
      {instrValid, romReturn} = 2'b00;
      chk(supervisoryRomMode_r, 1'b1);
      romReturn = 1'b1;
      @(negedge clk);
      romReturn = 1'b0;
      chk(supervisoryRomMode_r, 1'b0);
      // a second request in mid-entry must not restart the count
      irqTake = 1'b1;
      @(negedge clk);
      n = 0;
      while (irqEntryBusy_r === 1'b1 && n < 20) begin
         n++;
         irqTake = (n == 4);
         @(negedge clk);
      end
      irqTake = 1'b0;
      chk(n, 13);
      chk(vectorFetch_r, 1'b1);
      instr(8'h40, 16'h00ff, 2'h2, 4'h5);
      instr(8'h40, 16'h00fe, 2'h2, 4'h5);
      instr(8'h40, 16'h00fe, 2'h3, 4'hf);
      instr(8'h40, 16'h0100, 2'h0, 4'h4);
      instr(8'h40, 16'hffff, 2'h2, 4'h7);
      repeat (40) begin
         seed = lfsr(seed);
         instr(seed[7:0] | 8'h01, seed[23:8], seed[25:24], seed[29:26]);
      end
      // a low clock enable freezes state, so the call is not taken
      ce = 1'b0;
      instrOpcode = `SUPV_CALL_OPCODE;
      repeat (3) @(negedge clk);
      chk({supervisoryRomMode_r, instrCyclesValid_r}, 2'b01);
      {ce, instrValid} = 2'b10;
      chk(supervisoryRomMode_r, 1'b0);
      ramReq = 1'b1;
      ramWr = 1'b1;
      repeat (16) begin
         seed = lfsr(seed);
         ramAddr = seed[7:0];
         ramWdata = seed[15:8];
         mem[seed[7:0]] = seed[15:8];
         aq.push_back(seed[7:0]);
         @(negedge clk);
      end
      ramWr = 1'b0;
      foreach (aq[i]) begin
         ramAddr = aq[i];
         @(negedge clk);
         chk(ramRdata, mem[aq[i]]);
      end
      ramReq = 1'b0;
      completeRun;
   end
endmodule
`default_nettype wire
